// file: logic/ulrd_pkg.sv
package ulrd_pkg;

  // Register byte offsets on the Wishbone port
  localparam logic [7:0] ULRD_OFF_CTRL = 8'h00;
  localparam logic [7:0] ULRD_OFF_CTRL_SET = 8'h04;
  localparam logic [7:0] ULRD_OFF_CTRL_CLR = 8'h08;
  localparam logic [7:0] ULRD_OFF_STATUS = 8'h0C;
  localparam logic [7:0] ULRD_OFF_STATE = 8'h10;

  // Control register field layout
  localparam int ULRD_CTRL_W = 7;
  localparam int ULRD_POS_SPEED = 0;
  localparam int ULRD_POS_TERM = 2;
  localparam int ULRD_POS_OPMODE = 3;
  localparam int ULRD_POS_DP_PD = 5;
  localparam int ULRD_POS_DM_PD = 6;

  // Status register field layout
  localparam int ULRD_POS_PULLUP_EN = 0;
  localparam int ULRD_POS_DP_PD_EN = 1;
  localparam int ULRD_POS_DM_PD_EN = 2;
  localparam int ULRD_POS_HS_TERMINATION_ENABLE = 3;

  // State register field layout
  localparam int ULRD_POS_STATE = 0;
  localparam int ULRD_POS_LISTED = 8;

  // Reset leaves the line in the power-up setting: full speed, pull-downs on
  localparam logic [6:0] ULRD_CTRL_RESET = 7'h61;

  localparam logic [1:0] ULRD_SPEED_HS = 2'h0;

  typedef enum logic [1:0] {
    ULRD_OPM_NORMAL = 2'h0,
    ULRD_OPM_TRISTATE = 2'h1,
    ULRD_OPM_NO_NRZI = 2'h2,
    ULRD_OPM_RESERVED = 2'h3
  } ulrd_opmode_t;

  typedef enum logic [4:0] {
    ULRD_ST_TRISTATE = 5'h00,
    ULRD_ST_POWERUP = 5'h01,
    ULRD_ST_HOST_CHIRP_TEST = 5'h02,
    ULRD_ST_HOST_HS = 5'h03,
    ULRD_ST_HOST_FS_SUSPEND = 5'h04,
    ULRD_ST_HOST_FS = 5'h05,
    ULRD_ST_HOST_FS_RESUME = 5'h06,
    ULRD_ST_HOST_LS_SUSPEND = 5'h07,
    ULRD_ST_HOST_LS_RESUME = 5'h08,
    ULRD_ST_PERI_CHIRP = 5'h09,
    ULRD_ST_PERI_HS = 5'h0A,
    ULRD_ST_PERI_FS_SUSPEND = 5'h0B,
    ULRD_ST_PERI_RESUME = 5'h0C,
    ULRD_ST_PERI_TEST = 5'h0D,
    ULRD_ST_OTG_CHIRP = 5'h0E,
    ULRD_ST_OTG_HS = 5'h0F,
    ULRD_ST_OTG_FS_SUSPEND = 5'h10,
    ULRD_ST_OTG_RESUME = 5'h11,
    ULRD_ST_OTG_TEST = 5'h12,
    ULRD_ST_UNLISTED = 5'h1F
  } ulrd_sig_state_t;

endpackage

// file: logic/ulrd_line_if.sv
`timescale 1ns/10ps
interface ulrd_line_if;
  import ulrd_pkg::*;

  logic [1:0] transceiver_speed_select;
  logic termination_select;
  ulrd_opmode_t operating_mode_select;
  logic dplus_pulldown_ctrl;
  logic dminus_pulldown_ctrl;

  logic dplus_pullup_enable;
  logic dplus_pulldown_enable;
  logic dminus_pulldown_enable;
  logic hs_termination_enable;

  ulrd_sig_state_t sig_state;
  logic sig_listed;

  modport owner (
    output transceiver_speed_select,
    output termination_select,
    output operating_mode_select,
    output dplus_pulldown_ctrl,
    output dminus_pulldown_ctrl,
    input dplus_pullup_enable,
    input dplus_pulldown_enable,
    input dminus_pulldown_enable,
    input hs_termination_enable,
    input sig_state,
    input sig_listed
  );

  modport decoder (
    input transceiver_speed_select,
    input termination_select,
    input operating_mode_select,
    input dplus_pulldown_ctrl,
    input dminus_pulldown_ctrl,
    output dplus_pullup_enable,
    output dplus_pulldown_enable,
    output dminus_pulldown_enable,
    output hs_termination_enable
  );

  modport classifier (
    input transceiver_speed_select,
    input termination_select,
    input operating_mode_select,
    input dplus_pulldown_ctrl,
    input dminus_pulldown_ctrl,
    output sig_state,
    output sig_listed
  );
endinterface

// file: logic/ulrd_decode.sv
`timescale 1ns/10ps
module ulrd_decode (
  ulrd_line_if.decoder line
);
  import ulrd_pkg::*;

  // Pure function of the five settings, no storage: a new setting reaches
  // the resistors without waiting on any bus event
  wire tristate = line.operating_mode_select == ULRD_OPM_TRISTATE;
  wire hs_speed = line.transceiver_speed_select == ULRD_SPEED_HS;

  assign line.dplus_pullup_enable = ~tristate & line.termination_select &
    ~line.dplus_pulldown_ctrl;
  assign line.dplus_pulldown_enable = ~tristate &
    line.dplus_pulldown_ctrl;
  assign line.dminus_pulldown_enable = ~tristate &
    line.dminus_pulldown_ctrl;
  assign line.hs_termination_enable = ~tristate & hs_speed &
    ~line.termination_select;
endmodule // ulrd_decode

// file: logic/ulrd_classify.sv
`timescale 1ns/10ps
module ulrd_classify (
  ulrd_line_if.classifier line
);
  import ulrd_pkg::*;

  // Readback only; the link alone picks the signalling state
  wire [6:0] key = {line.transceiver_speed_select, line.termination_select,
    line.operating_mode_select, line.dplus_pulldown_ctrl,
    line.dminus_pulldown_ctrl};
  wire tristate = line.operating_mode_select == ULRD_OPM_TRISTATE;

  ulrd_sig_state_t state_c;

  // Rows with identical settings cannot be told apart and share a code
  always_comb
  begin
    case (key)
      7'h23: state_c = ULRD_ST_POWERUP;
      7'h0B: state_c = ULRD_ST_HOST_CHIRP_TEST;
      7'h03: state_c = ULRD_ST_HOST_HS;
      7'h33: state_c = ULRD_ST_HOST_FS_SUSPEND;
      7'h73: state_c = ULRD_ST_HOST_FS;
      7'h3B: state_c = ULRD_ST_HOST_FS_RESUME;
      7'h53: state_c = ULRD_ST_HOST_LS_SUSPEND;
      7'h5B: state_c = ULRD_ST_HOST_LS_RESUME;
      7'h18: state_c = ULRD_ST_PERI_CHIRP;
      7'h00: state_c = ULRD_ST_PERI_HS;
      7'h30: state_c = ULRD_ST_PERI_FS_SUSPEND;
      7'h38: state_c = ULRD_ST_PERI_RESUME;
      7'h08: state_c = ULRD_ST_PERI_TEST;
      7'h19: state_c = ULRD_ST_OTG_CHIRP;
      7'h01: state_c = ULRD_ST_OTG_HS;
      7'h31: state_c = ULRD_ST_OTG_FS_SUSPEND;
      7'h39: state_c = ULRD_ST_OTG_RESUME;
      7'h09: state_c = ULRD_ST_OTG_TEST;
      default: state_c = ULRD_ST_UNLISTED;
    endcase
  end

  assign line.sig_state = tristate ? ULRD_ST_TRISTATE : state_c;
  assign line.sig_listed = line.sig_state != ULRD_ST_UNLISTED;
endmodule // ulrd_classify

// file: logic/ulrd_top.sv
// Summary of operation
// - Enables come from speed, termination, mode and two pull-down bits.
// - Operating mode 01b turns every resistor enable off.
// - D+ pull-up on only with termination select 1 and D+ pull-down 0.
// - D+ pull-down enable follows the D+ pull-down control bit.
// - D- pull-down enable follows the D- pull-down control bit.
// - HS terminations on only with speed 00b and termination select 0.
//
// Design decisions made here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module ulrd_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic dplus_pullup_enable,
  output logic dplus_pulldown_enable,
  output logic dminus_pulldown_enable,
  output logic hs_termination_enable
);
  import ulrd_pkg::*;

  function automatic logic addr_is(input logic [7:0] adr,
                                   input logic [7:0] off);
    addr_is = adr == off;
  endfunction

  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [ULRD_CTRL_W-1:0] ctrl_q;
  logic [ULRD_CTRL_W-1:0] ctrl_d;

  ulrd_line_if line ();

  // Bus decode; misaligned byte addresses match no register
  wire req = wb_cyc_i & wb_stb_i;
  wire start = req & ~ack_q;
  wire hit_ctrl = addr_is(wb_adr_i, ULRD_OFF_CTRL);
  wire hit_set = addr_is(wb_adr_i, ULRD_OFF_CTRL_SET);
  wire hit_clr = addr_is(wb_adr_i, ULRD_OFF_CTRL_CLR);
  wire hit_status = addr_is(wb_adr_i, ULRD_OFF_STATUS);
  wire hit_state = addr_is(wb_adr_i, ULRD_OFF_STATE);

  // Write lands on the edge where the master sees ack; all fields sit
  // in byte lane 0, so only that lane gates the write
  wire wr_lane0 = req & ack_q & wb_we_i & wb_sel_i[0];
  wire [ULRD_CTRL_W-1:0] wdat = wb_dat_i[ULRD_CTRL_W-1:0];

  // Set and clear aliases avoid read-modify-write by the link
  assign ctrl_d = !wr_lane0 ? ctrl_q :
                  hit_ctrl ? wdat :
                  hit_set ? (ctrl_q | wdat) :
                  hit_clr ? (ctrl_q & ~wdat) :
                  ctrl_q;

  // Control fields onto the carrier toward decoder and classifier
  assign line.transceiver_speed_select =
    ctrl_q[ULRD_POS_SPEED +: 2];
  assign line.termination_select = ctrl_q[ULRD_POS_TERM];
  assign line.operating_mode_select =
    ulrd_opmode_t'(ctrl_q[ULRD_POS_OPMODE +: 2]);
  assign line.dplus_pulldown_ctrl = ctrl_q[ULRD_POS_DP_PD];
  assign line.dminus_pulldown_ctrl = ctrl_q[ULRD_POS_DM_PD];

  ulrd_decode u_decode (
    .line(line.decoder)
  );

  ulrd_classify u_classify (
    .line(line.classifier)
  );

  // Enables leave combinationally from the control register so that a
  // setting acts in the cycle after its write edge, never later
  assign dplus_pullup_enable = line.dplus_pullup_enable;
  assign dplus_pulldown_enable = line.dplus_pulldown_enable;
  assign dminus_pulldown_enable = line.dminus_pulldown_enable;
  assign hs_termination_enable = line.hs_termination_enable;

  wire [31:0] ctrl_word = {{(32 - ULRD_CTRL_W){1'b0}}, ctrl_q};
  wire [31:0] status_word = {28'h000_0000,
    line.hs_termination_enable, line.dminus_pulldown_enable,
    line.dplus_pulldown_enable, line.dplus_pullup_enable};
  wire [31:0] state_word = {23'h00_0000, line.sig_listed, 3'h0,
    line.sig_state};

  // Unmapped addresses read as zero and are still acknowledged
  assign rdat_d = (hit_ctrl | hit_set | hit_clr) ? ctrl_word :
                  hit_status ? status_word :
                  hit_state ? state_word :
                  32'h0000_0000;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      ctrl_q <= ULRD_CTRL_RESET;
    end
    else
    begin
      ack_q <= start;
      ctrl_q <= ctrl_d;
      if (start)
      begin
        rdat_q <= rdat_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
endmodule // ulrd_top

// file: tb/ulrd_top_assertions.sv
`timescale 1ns/10ps
module ulrd_top_assertions (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic dplus_pullup_enable,
  input wire logic dplus_pulldown_enable,
  input wire logic dminus_pulldown_enable,
  input wire logic hs_termination_enable
);
  import ulrd_pkg::*;
  wire logic req = wb_cyc_i && wb_stb_i;
  wire logic ctrl_wr = wb_ack_o && req && wb_we_i && wb_sel_i[0] &&
    wb_adr_i == ULRD_OFF_CTRL;
  wire logic off_mode = wb_dat_i[4:3] == 2'h1;
  wire logic exp_pu = wb_dat_i[2] && !wb_dat_i[5];
  wire logic exp_hs = wb_dat_i[1:0] == 2'h0 && !wb_dat_i[2];
  wire logic [3:0] outs = {hs_termination_enable, dminus_pulldown_enable,
    dplus_pulldown_enable, dplus_pullup_enable};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  a_tristate_all_off: assert property (ctrl_wr && off_mode |=>
    outs == 4'h0) else $error("enables on in tristate mode");
  a_pullup_decode: assert property (ctrl_wr && !off_mode |=>
    dplus_pullup_enable == $past(exp_pu)) else $error("pull-up decode");
  a_dplus_pd_follow: assert property (ctrl_wr && !off_mode |=>
    dplus_pulldown_enable == $past(wb_dat_i[5])) else $error("D+ pd");
  a_dminus_pd_follow: assert property (ctrl_wr && !off_mode |=>
    dminus_pulldown_enable == $past(wb_dat_i[6])) else $error("D- pd");
  a_hsterm_decode: assert property (ctrl_wr && !off_mode |=>
    hs_termination_enable == $past(exp_hs)) else $error("hs term decode");
  a_pullup_exclusive: assert property (dplus_pullup_enable |->
    !dplus_pulldown_enable && !hs_termination_enable) else $error("pu mix");
  a_outs_hold_idle: assert property (!(wb_ack_o && wb_we_i) |=>
    $stable(outs)) else $error("enables moved without a write");
  a_ack_next_cycle: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("no ack in one cycle");
  a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule // ulrd_top_assertions

bind ulrd_top ulrd_top_assertions u_chk (.*);

// file: tb/ulrd_link_model.sv
`timescale 1ns/10ps
module ulrd_link_model (
  input wire logic clk_sys,
  input wire logic wb_ack_o,
  output logic wb_cyc_i,
  output logic wb_stb_i,
  output logic wb_we_i,
  output logic [7:0] wb_adr_i,
  output logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_i
);
  initial
  begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
  end
  // The link alone picks the line state
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [3:0] s, input logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    // Released lines must not keep showing the old value
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
  endtask
endmodule // ulrd_link_model

// file: tb/ulrd_top_tb.sv
`timescale 1ns/10ps
module ulrd_top_tb;
  import ulrd_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  // Four port connections drive separate bits, so a net is needed here
  wire [3:0] outs;
  logic [31:0] wb_dat_i, wb_dat_o, e;
  logic [31:0] lfsr = 32'h1020_4033;
  logic [31:0] exp_q[$];
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  ulrd_link_model link (.clk_sys(clk_sys), .wb_ack_o(wb_ack_o),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));
  ulrd_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dplus_pullup_enable(outs[0]),
    .dplus_pulldown_enable(outs[1]), .dminus_pulldown_enable(outs[2]),
    .hs_termination_enable(outs[3]));
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [31:0] dec(input logic [6:0] c);
    if (c[4:3] == 2'h1)
      return 32'h0000_0000;
    return {28'h0, c[1:0] == 2'h0 && !c[2], c[6], c[5], c[2] && !c[5]};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    link.xfer(1'b1, a, 4'h1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    link.xfer(1'b0, a, 4'hF, lfsr);
  endtask
  task automatic test_done();
    $display("Compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Pins are checked on STATUS reads, long after the write has settled
  always @(posedge clk_sys)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
      n_compared++;
      if (wb_dat_o !== e ||
        (wb_adr_i == ULRD_OFF_STATUS && outs !== e[3:0]))
      begin
        error_cnt++;
        $display("Error %0t got %h/%h exp %h", $time, wb_dat_o, outs, e);
      end
    end
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      error_cnt++;
      test_done();
    end
  end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ULRD_OFF_CTRL, {25'h000_0000, ULRD_CTRL_RESET});
    rd(ULRD_OFF_STATUS, dec(ULRD_CTRL_RESET));
    rd(ULRD_OFF_STATE, {23'h00_0000, 1'b1, 3'h0, ULRD_ST_POWERUP});
    for (int i = 0; i < 128; i++)
    begin
      lfsr = lfsr_next(lfsr);
      wr(ULRD_OFF_CTRL, {lfsr[31:7], i[6:0]});
      rd(ULRD_OFF_STATUS, dec(i[6:0]));
      rd(ULRD_OFF_CTRL, {25'h0, i[6:0]});
    end
    rd(ULRD_OFF_STATUS, dec(7'h7F));
    // Clear first, so that the set alias really has bits to raise
    wr(ULRD_OFF_CTRL_CLR, 32'h0000_003F);
    rd(ULRD_OFF_STATUS, dec(7'h40));
    rd(ULRD_OFF_STATE, {23'h00_0000, 1'b1, 3'h0, ULRD_ST_OTG_HS});
    wr(ULRD_OFF_CTRL_SET, 32'h0000_0004);
    rd(ULRD_OFF_CTRL_SET, 32'h0000_0044);
    rd(ULRD_OFF_STATUS, dec(7'h44));
    rd(ULRD_OFF_STATE, {23'h00_0000, 1'b0, 3'h0, ULRD_ST_UNLISTED});
    // Lane 0 off: this write of zero must leave the control word alone
    link.xfer(1'b1, ULRD_OFF_CTRL, 4'hE, 32'h0000_0000);
    wr(8'h14, 32'hFFFF_FFFF);
    wr(ULRD_OFF_STATUS, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    rd(ULRD_OFF_STATUS, dec(7'h44));
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(ULRD_OFF_STATUS, dec(ULRD_CTRL_RESET));
    test_done();
  end
endmodule // ulrd_top_tb
